// File: monitor_select_pkg.sv
// How it works
// [R1] Select codes 1 to 10 each route one monitored node, in the order the package lists them.
// [R2] The all-zero select code leaves the monitor output pin undriven.
// [R3] The output buffer is powered only while the select code is nonzero.
// [R4] The host converts the discharge null channel before any discharge current reading.
// [R5] The host waits the switching time of about 0.3 us after each select change.
// [R6] The host selects discharge current straight after the null conversion.
// [R7] Charge current is read at code 4 after the switching time, with no null step.
// [R8] Discharge full scale comes from a separate 4-bit scale field whose default means 300 mA.
// [R9] Charge-current full scale follows the 6-bit fast-charge current setting.
// [R10] Status 0 to 2 means discharging; charging needs the flag, state 1 to 7 and status 3.
// [R11] Battery-current selections are honoured in every state, never gated by charger activity.
// [R12] The thermistor bias turns on while the thermistor or bias node is routed out.
// [R13] The bias also turns on while the input is valid and thermistor monitoring is enabled.
// [R14] A select write reaches routing and buffer enable the cycle after the register update.
`default_nettype none
package monitor_select_pkg;
    localparam logic [3:0] SEL_OFF = 4'h0;
    localparam logic [3:0] SEL_INPUT_V = 4'h1;
    localparam logic [3:0] SEL_INPUT_I = 4'h2;
    localparam logic [3:0] SEL_CELL_V = 4'h3;
    localparam logic [3:0] SEL_CHARGE_I = 4'h4;
    localparam logic [3:0] SEL_DISCHG_I = 4'h5;
    localparam logic [3:0] SEL_DISCHG_NULL = 4'h6;
    localparam logic [3:0] SEL_THERM = 4'h7;
    localparam logic [3:0] SEL_BIAS = 4'h8;
    localparam logic [3:0] SEL_GROUND = 4'h9;
    localparam logic [3:0] SEL_RAIL = 4'hA;
    localparam int CHANNELS = 10;
    localparam logic [1:0] INPUT_ST_VALID = 2'h3;
    localparam logic [3:0] CHARGE_ST_MIN = 4'h1;
    localparam logic [3:0] CHARGE_ST_MAX = 4'h7;
    // Reset code of the discharge scale field, meaning 300 mA full scale
    localparam logic [3:0] DISCHG_SCALE_RESET = 4'h0;
    localparam logic [5:0] FAST_CHARGE_RESET = 6'h00;
    localparam int SWITCH_TIME_NS = 300;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// File: monitor_channel_decode.sv
`timescale 1ns/1ns
`default_nettype none
// One-hot decode of the select code; unused codes route nothing
module monitor_channel_decode
(
    input wire logic [3:0] sel,
    output logic [monitor_select_pkg::CHANNELS-1:0] route
);
    genvar i;
    generate
        for (i = 0; i < monitor_select_pkg::CHANNELS; i++)
        begin : g_ch
            assign route[i] = (sel == 4'(i + 1)); // R1
        end
    endgenerate
endmodule
`default_nettype wire

// File: analog_monitor_select.sv
`timescale 1ns/1ns
`default_nettype none
module analog_monitor_select
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic select_write,
    input wire logic [3:0] monitor_channel_select,
    input wire logic scale_write,
    input wire logic [3:0] discharge_monitor_full_scale,
    input wire logic fast_charge_write,
    input wire logic [5:0] fast_charge_current_setting,
    input wire logic thermistor_monitor_enable,
    input wire logic charger_input_valid,
    input wire logic charging_active_flag,
    input wire logic [3:0] charger_state_details,
    input wire logic [1:0] charger_input_details,
    output logic [monitor_select_pkg::CHANNELS-1:0] channel_route,
    output logic buffer_enable,
    output logic monitor_output_oe,
    output logic thermistor_bias_on,
    output logic [3:0] discharge_scale,
    output logic [5:0] charge_full_scale,
    output logic battery_charging,
    output logic [3:0] select_readback,
    output logic settle_done
);
    // Synchronisers for inputs coming from the analog domain
    logic vin_s1_r, vin_s2_r;
    logic flag_s1_r, flag_s2_r;
    logic [3:0] state_s1_r, state_s2_r;
    logic [1:0] input_s1_r, input_s2_r;

    logic [3:0] sel_r;
    logic [3:0] scale_r;
    logic [5:0] fcc_r;
    logic [7:0] settle_r;
    logic [monitor_select_pkg::CHANNELS-1:0] route_nxt;
    logic bias_nxt;
    logic charging_nxt;
    logic sel_nz;
    logic ch_ok;

    monitor_channel_decode u_dec
    (
        .sel(sel_r),
        .route(route_nxt)
    );

    // Decode of the stored select code and status
    assign sel_nz = (sel_r != monitor_select_pkg::SEL_OFF); // R3
    assign bias_nxt = (sel_r == monitor_select_pkg::SEL_THERM) // R12
        || (sel_r == monitor_select_pkg::SEL_BIAS)
        || (vin_s2_r && thermistor_monitor_enable); // R13
    assign ch_ok = (state_s2_r >= monitor_select_pkg::CHARGE_ST_MIN)
        && (state_s2_r <= monitor_select_pkg::CHARGE_ST_MAX);
    assign charging_nxt = flag_s2_r && ch_ok
        && (input_s2_r == monitor_select_pkg::INPUT_ST_VALID); // R10

    // Two-stage synchronisers; only stage two is read
    always_ff @(posedge clk)
    begin
        vin_s1_r <= charger_input_valid;
        vin_s2_r <= vin_s1_r;
        flag_s1_r <= charging_active_flag;
        flag_s2_r <= flag_s1_r;
        state_s1_r <= charger_state_details;
        state_s2_r <= state_s1_r;
        input_s1_r <= charger_input_details;
        input_s2_r <= input_s1_r;
    end

    // Configuration fields; the select is deliberately not gated on charger state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sel_r <= monitor_select_pkg::SEL_OFF;
            scale_r <= monitor_select_pkg::DISCHG_SCALE_RESET;
            fcc_r <= monitor_select_pkg::FAST_CHARGE_RESET;
        end
        else
        begin
            if (select_write)
                sel_r <= monitor_channel_select; // R11
            if (scale_write)
                scale_r <= discharge_monitor_full_scale; // R8
            if (fast_charge_write)
                fcc_r <= fast_charge_current_setting; // R9
        end
    end

    // Outputs registered one cycle after the field update
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            channel_route <= '0;
            buffer_enable <= 1'b0;
            monitor_output_oe <= 1'b0;
            thermistor_bias_on <= 1'b0;
            discharge_scale <= monitor_select_pkg::DISCHG_SCALE_RESET;
            charge_full_scale <= monitor_select_pkg::FAST_CHARGE_RESET;
            battery_charging <= 1'b0;
            select_readback <= monitor_select_pkg::SEL_OFF;
        end
        else
        begin
            channel_route <= route_nxt; // R14
            buffer_enable <= sel_nz; // R3
            monitor_output_oe <= sel_nz; // R2
            thermistor_bias_on <= bias_nxt;
            discharge_scale <= scale_r; // R8
            charge_full_scale <= fcc_r; // R9
            battery_charging <= charging_nxt; // R10
            select_readback <= sel_r;
        end
    end

    // Settling aid for the host: counts the switching time after a select change
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            settle_r <= 8'h00;
            settle_done <= 1'b0;
        end
        else if (select_write && monitor_channel_select != sel_r)
        begin
            settle_r <= 8'(monitor_select_pkg::SWITCH_CYCLES); // R5
            settle_done <= 1'b0;
        end
        else if (settle_r != 8'h00)
        begin
            settle_r <= settle_r - 8'h01;
            settle_done <= 1'b0;
        end
        else
            settle_done <= sel_nz;
    end

    // Reference routing for the assertions, built by shifting rather than comparing
    function automatic logic [monitor_select_pkg::CHANNELS-1:0] onehot_of
    (
        input logic [3:0] code
    );
        logic [monitor_select_pkg::CHANNELS-1:0] one;
        one = {{(monitor_select_pkg::CHANNELS - 1){1'b0}}, 1'b1};
        if (code == monitor_select_pkg::SEL_OFF || code > 4'(monitor_select_pkg::CHANNELS))
            return '0;
        return one << (code - 4'h1);
    endfunction

    property p_off_hiz;
        @(posedge clk) disable iff (!rst_n)
        ##1 (sel_r == monitor_select_pkg::SEL_OFF) |=> !monitor_output_oe;
    endproperty
    a_off_hiz: assert property (p_off_hiz) else $error("pin driven while off"); // R2

    property p_buf;
        @(posedge clk) disable iff (!rst_n)
        ##1 1'b1 |-> buffer_enable == ($past(sel_r) != monitor_select_pkg::SEL_OFF);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer enable wrong"); // R3

    property p_route;
        @(posedge clk) disable iff (!rst_n)
        select_write |=> ##1 channel_route == onehot_of($past(monitor_channel_select, 2))
            && $countones(channel_route) <= 1;
    endproperty
    a_route: assert property (p_route) else $error("routing late or not one-hot"); // R14

    property p_dec;
        @(posedge clk) disable iff (!rst_n)
        (sel_r == monitor_select_pkg::SEL_DISCHG_I)
        |=> channel_route[monitor_select_pkg::SEL_DISCHG_I - 4'h1];
    endproperty
    a_dec: assert property (p_dec) else $error("discharge channel not routed"); // R1

    property p_bias;
        @(posedge clk) disable iff (!rst_n)
        ((sel_r == monitor_select_pkg::SEL_THERM) || (sel_r == monitor_select_pkg::SEL_BIAS))
        |=> thermistor_bias_on;
    endproperty
    a_bias: assert property (p_bias) else $error("bias off for thermistor route"); // R12

    property p_bias_chg;
        @(posedge clk) disable iff (!rst_n)
        (vin_s2_r && thermistor_monitor_enable) |=> thermistor_bias_on;
    endproperty
    a_bias_chg: assert property (p_bias_chg) else $error("bias off with valid input"); // R13

    property p_dischg;
        @(posedge clk) disable iff (!rst_n)
        (input_s2_r != monitor_select_pkg::INPUT_ST_VALID) |=> !battery_charging;
    endproperty
    a_dischg: assert property (p_dischg) else $error("charging without valid input"); // R10

    property p_scale;
        @(posedge clk) disable iff (!rst_n)
        scale_write |=> ##1 discharge_scale == $past(discharge_monitor_full_scale, 2);
    endproperty
    a_scale: assert property (p_scale) else $error("scale not applied"); // R8

    property p_fcc;
        @(posedge clk) disable iff (!rst_n)
        fast_charge_write |=> ##1 charge_full_scale == $past(fast_charge_current_setting, 2);
    endproperty
    a_fcc: assert property (p_fcc) else $error("fast charge scale not applied"); // R9

    property p_any;
        @(posedge clk) disable iff (!rst_n)
        (select_write && monitor_channel_select == monitor_select_pkg::SEL_CHARGE_I
            && !charging_active_flag) |=> sel_r == monitor_select_pkg::SEL_CHARGE_I;
    endproperty
    a_any: assert property (p_any) else $error("select gated by charger"); // R11

    property p_settle;
        @(posedge clk) disable iff (!rst_n)
        (select_write && monitor_channel_select != sel_r) |=> !settle_done [*8] ##1 !settle_done;
    endproperty
    a_settle: assert property (p_settle) else $error("settle flag early"); // R5

    c_null_then_dis: cover property (@(posedge clk) disable iff (!rst_n)
        sel_r == monitor_select_pkg::SEL_DISCHG_NULL ##[1:50]
        sel_r == monitor_select_pkg::SEL_DISCHG_I);
    c_charging: cover property (@(posedge clk) disable iff (!rst_n) battery_charging);
    c_bias: cover property (@(posedge clk) disable iff (!rst_n) thermistor_bias_on);
    c_settled: cover property (@(posedge clk) disable iff (!rst_n) $rose(settle_done));
endmodule
`default_nettype wire

// File: adc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module adc_host_model
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic monitor_output_oe,
    input wire logic [3:0] select_readback,
    input wire logic settle_done,
    output logic [15:0] conversions
);
    logic [3:0] last_r;
    logic taken_r;
    // One conversion per selection, never before the channel has settled
    always @(posedge clk)
    begin
        last_r <= select_readback;
        if (!rst_n)
        begin
            conversions <= 16'h0000;
            taken_r <= 1'b0;
        end
        else if (select_readback != last_r)
            taken_r <= 1'b0;
        else if (settle_done && monitor_output_oe && !taken_r)
        begin
            conversions <= conversions + 16'h0001;
            taken_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: tb_analog_monitor_select.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_analog_monitor_select;
    logic clk = 1'b0, rst_n = 1'b0, sw = 1'b0, scw = 1'b0, fw = 1'b0;
    logic ten = 1'b0, vld = 1'b0, flg = 1'b0, bufe, oe, bias, charging, sdone;
    logic [3:0] sel = 4'h0, scl = 4'h0, st = 4'h0, dsc, rb, sel_m = 4'h0, sc_m = 4'h0;
    logic [5:0] fc = 6'h00, fc_m = 6'h00, cfs;
    logic [1:0] det = 2'h0;
    logic [9:0] route;
    logic [15:0] convs, c0;
    logic [27:0] e;
    logic [27:0] exp_q[$];
    logic [3:0] codes[5] = '{4'h4, 4'h5, 4'h7, 4'h8, 4'h1};
    int num_errors = 0, n_compared = 0;
    event sample;
    wire logic [27:0] obs = {route, bufe, oe, bias, charging, rb, dsc, cfs};
    always #5 clk = ~clk;
    analog_monitor_select u_dut (.clk(clk), .rst_n(rst_n), .select_write(sw),
        .monitor_channel_select(sel), .scale_write(scw), .discharge_monitor_full_scale(scl),
        .fast_charge_write(fw), .fast_charge_current_setting(fc),
        .thermistor_monitor_enable(ten), .charger_input_valid(vld),
        .charging_active_flag(flg), .charger_state_details(st), .charger_input_details(det),
        .channel_route(route), .buffer_enable(bufe), .monitor_output_oe(oe),
        .thermistor_bias_on(bias), .discharge_scale(dsc), .charge_full_scale(cfs),
        .battery_charging(charging), .select_readback(rb), .settle_done(sdone));
    adc_host_model u_adc (.clk(clk), .rst_n(rst_n), .monitor_output_oe(oe),
        .select_readback(rb), .settle_done(sdone), .conversions(convs));
    // Expected outputs worked out from the select, scale and status the bench applied
    function automatic logic [27:0] model();
        logic [9:0] r;
        r = (sel_m >= 4'h1 && sel_m <= 4'hA) ? (10'h001 << (sel_m - 4'h1)) : 10'h000;
        return {r, sel_m != 4'h0, sel_m != 4'h0, (sel_m == 4'h7 || sel_m == 4'h8) || (vld && ten),
            flg && st >= 4'h1 && st <= 4'h7 && det == 2'h3, sel_m, sc_m, fc_m};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic note();
        exp_q.push_back(model());
        -> sample;
    endtask
    // Leaves the strobe high so back-to-back writes need no gap
    task automatic put_sel(input logic [3:0] c);
        sel = c;
        sw = 1'b1;
        tick(1);
        sel_m = c;
    endtask
    task automatic wait_settle();
        int n;
        n = 0;
        while (sdone !== 1'b1 && n < 200)
        begin
            tick(1);
            n++;
        end
        if (n == 200)
        begin
            num_errors++;
            $display("[FAIL] %0t settle wait timed out", $time);
            test_done();
        end
        `CHK(n >= monitor_select_pkg::SWITCH_CYCLES, 1'b1)
        tick(2);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Each note is compared against the settled outputs
    initial
    begin
        forever
        begin
            @(sample);
            e = exp_q.pop_front();
            `CHK(obs[27:18], e[27:18])
            `CHK(obs[16], e[16])
            `CHK(obs[17], e[17])
            `CHK(obs[15], e[15])
            `CHK(obs[14], e[14])
            `CHK(obs[13:10], e[13:10])
            `CHK(obs[9:6], e[9:6])
            `CHK(obs[5:0], e[5:0])
        end
    end
    initial
    begin
        void'($urandom(15));
        tick(3);
        rst_n = 1'b1;
        note();
        $display("test reset done");
        for (int c = 0; c < 16; c++)
        begin
            put_sel(4'(c));
            sw = 1'b0;
            tick(1);
            note();
        end
        put_sel(4'h3);
        put_sel(4'h9);
        sw = 1'b0;
        tick(1);
        note();
        $display("test codes done");
        // Status lines cross a synchroniser, so allow four edges before looking
        for (int i = 0; i < 24; i++)
        begin
            {flg, st, det, vld, ten} = 9'($urandom);
            if (i % 3 == 0)
                {flg, det} = 3'h7;
            put_sel(codes[$urandom_range(4)]);
            sw = 1'b0;
            tick(3);
            note();
        end
        $display("test status done");
        for (int i = 0; i < 8; i++)
        begin
            scl = 4'($urandom);
            fc = 6'($urandom);
            {scw, fw} = 2'h3;
            tick(1);
            {scw, fw} = 2'h0;
            {sc_m, fc_m} = {scl, fc};
            tick(1);
            note();
        end
        $display("test scale done");
        put_sel(4'h6);
        sw = 1'b0;
        // Taken after the null write, so a late count for the old channel cannot leak in
        c0 = convs;
        wait_settle();
        put_sel(4'h5);
        sw = 1'b0;
        wait_settle();
        put_sel(4'h4);
        sw = 1'b0;
        wait_settle();
        note();
        `CHK(convs - c0, 16'h0003)
        $display("test sequence done");
        tick(1);
        test_done();
    end
endmodule
`default_nettype wire
